/* core/modbus_cfg_pkg.sv */
// Purpose: Shared constants and types for the serial configuration block.
// Assumes: 100 MHz system clock, Avalon-MM byte addresses, one word per register.
// Notes: Baud divisors are derived from the clock rate given by the caller.
package modbus_cfg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] OFF_FORMAT = 5'h00;
  localparam logic [4:0] OFF_BAUD = 5'h04;
  localparam logic [4:0] OFF_STATION = 5'h08;
  localparam logic [4:0] OFF_CTRL = 5'h0c;
  localparam logic [4:0] OFF_ACTIVE = 5'h10;
  localparam logic [4:0] OFF_DROPS = 5'h14;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int FMT_MODE_BIT = 2;
  localparam int CTRL_RELOAD_BIT = 0;
  localparam int ACT_BAUD_LSB = 4;
  localparam int ACT_STN_LSB = 8;
  localparam int ACT_PEND_BIT = 16;
  localparam logic [2:0] FORMAT_RST = 3'h0;
  localparam logic [3:0] BAUD_RST = 4'h6;
  localparam logic [3:0] BAUD_MAX = 4'h9;
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hf7;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;

  // Stop and parity codes held in format bits 1:0.
  localparam logic [1:0] SP_TWO_NONE = 2'h0;
  localparam logic [1:0] SP_ONE_NONE = 2'h1;
  localparam logic [1:0] SP_ONE_EVEN = 2'h2;
  localparam logic [1:0] SP_ONE_ODD = 2'h3;

  // ----------------------------------------
  // Register number mapping limits
  // ----------------------------------------
  localparam logic [16:0] STD_MUL = 17'h00064;
  localparam logic [16:0] STD_MENU_MAX = 17'h000a2;
  localparam logic [8:0] MOD_MENU_MAX = 9'h03f;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int DIV_W = 20;

  typedef enum logic [2:0] {
    RL_IDLE = 3'b001,
    RL_DEFER = 3'b010,
    RL_APPLY = 3'b100
  } reload_st_t;

  // Cycles per bit for a baud code; unknown codes fall back to the default rate.
  function automatic logic [DIV_W-1:0] baud_div(input int clk_hz, input logic [3:0] code);
    int rate;
    unique case (code)
      4'h0: rate = 300;
      4'h1: rate = 600;
      4'h2: rate = 1200;
      4'h3: rate = 2400;
      4'h4: rate = 4800;
      4'h5: rate = 9600;
      4'h7: rate = 38400;
      4'h8: rate = 57600;
      4'h9: rate = 115200;
      default: rate = 19200;
    endcase
    baud_div = DIV_W'(clk_hz / rate);
  endfunction

endpackage

/* core/cfg_pair_buffer.sv */
// Purpose: Small valid/ready buffer between the decoder and the frame handler.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Holds DEPTH words so a stalled receiver never loses one.
`timescale 1ns/1ps
module cfg_pair_buffer #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_state_t;

  buf_state_t s_q;
  buf_state_t s_d;
  logic push;
  logic pop;

  assign in_ready = s_q.cnt != CW'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : s_q.wp + PW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : s_q.rp + PW'(1);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + CW'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // cfg_pair_buffer

/* core/cfg_baud_divider.sv */
// Purpose: Bit-rate enable generator for the serial link.
// Assumes: Divisor of at least one cycle.
// Notes: Restart realigns the bit grid when new settings are applied.
`timescale 1ns/1ps
module cfg_baud_divider #(
  parameter int CW = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [CW-1:0] div,
  // Enable out
  output logic tick
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  assign tick = s_q.tick;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= div - CW'(1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // cfg_baud_divider

/* core/modbus_slave_serial_config.sv */
// Purpose: Serial port settings and station/register decode for an RTU slave.
// Assumes: Frame parser delivers one request header per handshake.
// Notes: Stored settings become active only through a reload.
//
// How it works
// [R1] Format bits 1:0 pick two stop/no parity, one stop/no parity, one stop/even or one stop/odd.
// [R2] Format bit 2 picks standard register numbering when clear and modified numbering when set.
// [R3] Standard numbering splits address plus one into menu times 100 and a parameter, menu up to 162.
// [R4] Modified numbering splits address plus one into menu times 256 and a parameter, menu up to 63.
// [R5] Parameters above 99 in menus above 63 are reachable by neither scheme and flag out of range.
// [R6] Writes to format, baud and station only change stored copies until a reload copies them over.
// [R7] A reload caused by a link command waits until the reply to it has gone out at the old rate.
// [R8] The master waits 20 ms after a rate change before talking at the new rate.
// [R9] The station register takes only 1 to 247, resets to 1, and own-address frames are answered.
// [R10] Address 0 is a broadcast to all slaves and is refused as a station address.
// [R11] The block only answers requests and never starts a transfer by itself.
// [R12] Format bit 3 selects the data width and always reads 0 since 8 data bits are required.
// [R13] The port always speaks RTU whatever format value is stored.
// [R14] Frames for other stations are dropped silently, broadcasts are handled without a reply.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module modbus_slave_serial_config #(
  parameter int CLK_HZ = modbus_cfg_pkg::CLK_HZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link events
  input wire logic link_reload,
  input wire logic reply_done,
  // Request headers in
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_station,
  input wire logic [15:0] req_reg_addr,
  input wire logic req_is_write,
  // Decoded requests out
  output logic dec_valid,
  input wire logic dec_ready,
  output logic [7:0] dec_menu,
  output logic [7:0] dec_param,
  output logic dec_in_range,
  output logic dec_broadcast,
  output logic dec_reply,
  output logic dec_is_write,
  // Active link settings
  output logic link_stop2,
  output logic link_parity_en,
  output logic link_parity_odd,
  output logic link_modified,
  output logic [3:0] link_baud_code,
  output logic link_baud_tick,
  output logic link_restart
);
  import modbus_cfg_pkg::*;

  localparam int DW = 20;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [2:0] fmt;
    logic [3:0] baud;
    logic [7:0] stn;
    logic [2:0] act_fmt;
    logic [3:0] act_baud;
    logic [7:0] act_stn;
    reload_st_t st;
    logic [15:0] drops;
    logic restart;
  } cfg_state_t;

  cfg_state_t s_q;
  cfg_state_t s_d;
  logic busy;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic [16:0] a1;
  logic [16:0] std_menu;
  logic [16:0] std_par;
  logic std_ok;
  logic [8:0] mod_menu;
  logic mod_ok;
  logic [7:0] menu;
  logic [7:0] param;
  logic in_range;
  logic is_bcast;
  logic is_own;
  logic match;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [DW-1:0] buf_in_data;
  logic [DW-1:0] buf_out_data;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // One wait state keeps the read mux off the bus path.
  assign busy = avs_read || avs_write;
  assign avs_waitrequest = busy && !s_q.ack;
  assign wr_fire = avs_write && s_q.ack && avs_byteenable[0];
  assign avs_readdata = s_q.rdata;

  always_comb begin
    rd_mux = '0;
    unique case (avs_address)
      // [R12] width bit reads zero
      OFF_FORMAT: rd_mux[2:0] = s_q.fmt;
      OFF_BAUD: rd_mux[3:0] = s_q.baud;
      OFF_STATION: rd_mux[7:0] = s_q.stn;
      OFF_ACTIVE: begin
        rd_mux[2:0] = s_q.act_fmt;
        rd_mux[ACT_BAUD_LSB +: 4] = s_q.act_baud;
        rd_mux[ACT_STN_LSB +: 8] = s_q.act_stn;
        rd_mux[ACT_PEND_BIT] = s_q.st != RL_IDLE;
      end
      OFF_DROPS: rd_mux[15:0] = s_q.drops;
      default: rd_mux = '0;
    endcase
  end

  // ----------------------------------------
  // Register number decode
  // ----------------------------------------
  assign a1 = {1'b0, req_reg_addr} + 17'h00001;
  // [R3] standard split
  assign std_menu = a1 / STD_MUL;
  assign std_par = a1 % STD_MUL;
  assign std_ok = std_menu <= STD_MENU_MAX;
  // [R4] modified split
  assign mod_menu = a1[16:8];
  assign mod_ok = mod_menu <= MOD_MENU_MAX;

  always_comb begin
    // [R2] scheme select
    if (s_q.act_fmt[FMT_MODE_BIT]) begin
      menu = mod_menu[7:0];
      param = a1[7:0];
      // [R5] menus above 63 unreachable
      in_range = mod_ok;
    end else begin
      menu = std_menu[7:0];
      param = std_par[7:0];
      // [R5] params above 99 unreachable
      in_range = std_ok;
    end
  end

  // ----------------------------------------
  // Station filter
  // ----------------------------------------
  // [R10] broadcast detect
  assign is_bcast = req_station == BROADCAST_ADDR;
  // [R9] own address match
  assign is_own = req_station == s_q.act_stn;
  assign match = is_bcast || is_own;
  // [R14] drop foreign frames
  assign req_ready = buf_in_ready || !match;
  assign buf_in_valid = req_valid && match;
  // [R11] reply only when asked
  assign buf_in_data = {req_is_write, in_range, is_bcast, is_own, menu, param};

  cfg_pair_buffer #(
    .WIDTH(DW),
    .DEPTH(2)
  ) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(dec_valid),
    .out_ready(dec_ready),
    .out_data(buf_out_data)
  );

  assign dec_is_write = buf_out_data[19];
  assign dec_in_range = buf_out_data[18];
  assign dec_broadcast = buf_out_data[17];
  assign dec_reply = buf_out_data[16];
  assign dec_menu = buf_out_data[15:8];
  assign dec_param = buf_out_data[7:0];

  // ----------------------------------------
  // Configuration and reload
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = busy && !s_q.ack;
    s_d.restart = 1'b0;
    if (avs_read && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    if (req_valid && !match && s_q.drops != 16'hffff) begin
      s_d.drops = s_q.drops + 16'h0001;
    end
    // [R6] stored copies only
    if (wr_fire) begin
      unique case (avs_address)
        OFF_FORMAT: s_d.fmt = avs_writedata[2:0];
        OFF_BAUD: begin
          if (avs_writedata[3:0] <= BAUD_MAX) begin
            s_d.baud = avs_writedata[3:0];
          end
        end
        // [R9] [R10] range 1 to 247
        OFF_STATION: begin
          if (avs_writedata[7:0] >= STATION_MIN && avs_writedata[7:0] <= STATION_MAX) begin
            s_d.stn = avs_writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    unique case (s_q.st)
      RL_IDLE: begin
        // [R7] link reload deferred
        if (link_reload) begin
          s_d.st = RL_DEFER;
        end else if (wr_fire && avs_address == OFF_CTRL && avs_writedata[CTRL_RELOAD_BIT]) begin
          s_d.st = RL_APPLY;
        end
      end
      RL_DEFER: begin
        // [R7] old rate until reply out
        if (reply_done) begin
          s_d.st = RL_APPLY;
        end
      end
      RL_APPLY: begin
        // [R6] apply stored settings
        s_d.act_fmt = s_q.fmt;
        s_d.act_baud = s_q.baud;
        s_d.act_stn = s_q.stn;
        s_d.restart = 1'b1;
        s_d.st = link_reload ? RL_DEFER : RL_IDLE;
      end
      default: s_d.st = RL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{ack: 1'b0, rdata: 32'h0, fmt: FORMAT_RST, baud: BAUD_RST, stn: STATION_RST,
               act_fmt: FORMAT_RST, act_baud: BAUD_RST, act_stn: STATION_RST, st: RL_IDLE,
               drops: 16'h0, restart: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Link settings
  // ----------------------------------------
  // [R1] stop and parity decode
  assign link_stop2 = s_q.act_fmt[1:0] == SP_TWO_NONE;
  assign link_parity_en = s_q.act_fmt[1:0] == SP_ONE_EVEN || s_q.act_fmt[1:0] == SP_ONE_ODD;
  assign link_parity_odd = s_q.act_fmt[1:0] == SP_ONE_ODD;
  // [R13] no protocol select exists
  assign link_modified = s_q.act_fmt[FMT_MODE_BIT];
  assign link_baud_code = s_q.act_baud;
  assign link_restart = s_q.restart;

  cfg_baud_divider #(
    .CW(DIV_W)
  ) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(s_q.restart),
    .div(baud_div(CLK_HZ, s_q.act_baud)),
    .tick(link_baud_tick)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_SP_DECODE: assert property (link_parity_en |-> s_q.act_fmt[1] && !link_stop2) // [R1]
    else $error("parity enabled with wrong stop/parity code");
  AST_MODE_SEL: assert property (buf_in_valid && s_q.act_fmt[FMT_MODE_BIT] |-> param == a1[7:0]) // [R2]
    else $error("modified mode parameter mismatch");
  AST_STD_MAP: assert property (buf_in_valid && !link_modified && in_range // [R3]
      |-> 17'(menu) * STD_MUL + 17'(param) == a1 && param <= 8'h63)
    else $error("standard map wrong");
  AST_MOD_MAP: assert property (buf_in_valid && link_modified && in_range // [R4]
      |-> {1'b0, menu, param} == a1 && menu <= 8'h3f)
    else $error("modified map wrong");
  AST_UNREACH: assert property (buf_in_valid && link_modified && a1[16:8] > 9'h03f |-> !in_range) // [R5]
    else $error("menu above 63 accepted");
  AST_HOLD_ACTIVE: assert property (s_q.st != RL_APPLY |=> $stable(s_q.act_baud) && $stable(s_q.act_stn)) // [R6]
    else $error("active settings changed without reload");
  AST_DEFER: assert property (s_q.st == RL_IDLE && link_reload |=> s_q.st == RL_DEFER ##0 // [R7]
      $stable(s_q.act_baud))
    else $error("link reload not deferred");
  AST_STN_RANGE: assert property (s_q.stn >= STATION_MIN && s_q.stn <= STATION_MAX) // [R9]
    else $error("station out of range");
  AST_STN_ZERO: assert property (wr_fire && avs_address == OFF_STATION && avs_writedata[7:0] == 8'h00 // [R10]
      |=> $stable(s_q.stn))
    else $error("station zero accepted");
  AST_NO_START: assert property ($rose(dec_valid) |-> $past(buf_in_valid && buf_in_ready)) // [R11]
    else $error("output without request");
  AST_BIT3: assert property (avs_read && !avs_waitrequest && avs_address == OFF_FORMAT // [R12]
      |-> avs_readdata[3] == 1'b0)
    else $error("data width bit set");
  AST_DROP: assert property (req_valid && !match |-> req_ready && !buf_in_valid) // [R14]
    else $error("foreign frame not dropped");
  AST_BCAST: assert property (dec_valid && dec_broadcast |-> !dec_reply) // [R14]
    else $error("broadcast marked for reply");

  COV_RELOAD_SW: cover property (s_q.st == RL_IDLE ##1 s_q.st == RL_APPLY ##1 s_q.restart);
  COV_RELOAD_LINK: cover property (s_q.st == RL_DEFER ##[1:20] s_q.st == RL_APPLY);
  COV_STALL_FULL: cover property (dec_valid && !dec_ready && !buf_in_ready);
  COV_BCAST: cover property (dec_valid && dec_ready && dec_broadcast);
endmodule // modbus_slave_serial_config

/* bench/rtu_master_model.sv */
// Purpose: Remote master model that offers request headers and link events.
// Assumes: The bench calls its tasks; single clock.
// Notes: Released header lines show the inverse of their last value.
`timescale 1ns/1ps
module rtu_master_model #(
  // Quiet time after a rate change: 20 ms at a 100 MHz clock.
  parameter int GAP_CYC = 2_000_000
) (
  // Clock
  input wire logic sys_clk,
  // Header handshake
  output logic req_valid,
  input wire logic req_ready,
  output logic [7:0] req_station,
  output logic [15:0] req_reg_addr,
  output logic req_is_write,
  // Link events
  output logic link_reload,
  output logic reply_done
);
  initial begin
    req_valid = 1'b0;
    req_station = 8'h00;
    req_reg_addr = 16'h0000;
    req_is_write = 1'b0;
    link_reload = 1'b0;
    reply_done = 1'b0;
  end

  // The header is held until the slave takes it; a stalled slave is waited out.
  task automatic send_hdr(input logic [7:0] stn, input logic [15:0] adr, input logic wr);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_station <= stn;
    req_reg_addr <= adr;
    req_is_write <= wr;
    do begin
      @(posedge sys_clk);
    end while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    req_station <= ~stn;
    req_reg_addr <= ~adr;
    req_is_write <= ~wr;
  endtask

  task automatic pulse_evt(input logic done);
    @(posedge sys_clk);
    if (done) begin
      reply_done <= 1'b1;
    end else begin
      link_reload <= 1'b1;
    end
    @(posedge sys_clk);
    reply_done <= 1'b0;
    link_reload <= 1'b0;
    if (done) repeat (GAP_CYC) @(posedge sys_clk);
  endtask
endmodule // rtu_master_model

/* bench/tb_modbus_slave_serial_config.sv */
// Purpose: Self-checking bench for the serial configuration block.
// Assumes: Clock rate parameter lowered so baud ticks come quickly.
// Notes: Decoded words are collected by a monitor and compared in order.
`timescale 1ns/1ps
module tb_modbus_slave_serial_config;
  import modbus_cfg_pkg::*;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, link_reload, reply_done;
  logic [4:0] avs_address;
  logic [3:0] avs_byteenable, link_baud_code;
  logic [31:0] avs_writedata, avs_readdata, rd_q;
  logic req_valid, req_ready, req_is_write, dec_valid, dec_ready, dec_in_range, dec_broadcast;
  logic [7:0] req_station, dec_menu, dec_param, own_q;
  logic [15:0] req_reg_addr;
  logic dec_reply, dec_is_write, link_stop2, link_parity_en, link_parity_odd, link_modified;
  logic link_baud_tick, link_restart, md_q;
  logic [31:0] exp_q[$];
  logic [31:0] seen_q[$];
  int err_total, checked, cyc, n;

  modbus_slave_serial_config #(.CLK_HZ(1_000_000)) i_dut (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .link_reload, .reply_done, .req_valid, .req_ready,
    .req_station, .req_reg_addr, .req_is_write, .dec_valid, .dec_ready, .dec_menu, .dec_param,
    .dec_in_range, .dec_broadcast, .dec_reply, .dec_is_write, .link_stop2, .link_parity_en,
    .link_parity_odd, .link_modified, .link_baud_code, .link_baud_tick, .link_restart
  );
  // With the scaled 1 MHz rate, 20 ms of link quiet time is 20000 cycles.
  rtu_master_model #(.GAP_CYC(20_000)) i_master (
    .sys_clk, .req_valid, .req_ready, .req_station, .req_reg_addr, .req_is_write,
    .link_reload, .reply_done
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (dec_valid === 1'b1 && dec_ready === 1'b1)
      seen_q.push_back({12'h000, dec_menu, dec_param, dec_in_range, dec_broadcast, dec_reply, dec_is_write});
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("FAIL run_time expected 0 got %0d", cyc);
      tally_and_finish();
    end
  end

  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h got %h", nm, e, g);
    end
  endtask

  // ----------------------------------------
  // Register bus access
  // ----------------------------------------
  task automatic av_go(input logic [4:0] a, input logic rd, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic av_chk(input logic [4:0] a, input logic [31:0] e);
    av_go(a, 1'b1, 32'h0);
    cmp32("register", e, rd_q);
  endtask

  task automatic reload();
    av_go(OFF_CTRL, 1'b0, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp32("link_restart", 32'h1, {31'h0, link_restart});
    @(posedge sys_clk);
  endtask

  // Expected word worked out from the numbering rules, then the header is sent.
  task automatic send(input logic [7:0] stn, input logic [15:0] adr, input logic wr);
    int v, m;
    v = adr + 1;
    m = md_q ? v / 256 : v / 100;
    if (stn == 8'h00 || stn == own_q)
      exp_q.push_back({12'h000, 8'(m), 8'(v - m * (md_q ? 256 : 100)), (md_q ? m <= 63 : m <= 162),
                       stn == 8'h00, stn != 8'h00, wr});
    i_master.send_hdr(stn, adr, wr);
  endtask

  task automatic chk_dec();
    repeat (4) @(posedge sys_clk);
    cmp32("dec_count", exp_q.size(), seen_q.size());
    while (exp_q.size() > 0 && seen_q.size() > 0)
      cmp32("dec_word", exp_q.pop_front(), seen_q.pop_front());
    exp_q.delete();
    seen_q.delete();
  endtask

  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata, cyc, err_total, checked} = '0;
    avs_byteenable = 4'hf;
    dec_ready = 1'b1;
    own_q = 8'h05;
    md_q = 1'b1;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    av_chk(OFF_BAUD, 32'h6);
    av_chk(OFF_STATION, 32'h1);
    av_chk(OFF_ACTIVE, 32'h160);
    cmp32("stop2", 32'h1, {31'h0, link_stop2});
    $display("test reset done");
    av_go(OFF_FORMAT, 1'b0, 32'hf);
    av_chk(OFF_FORMAT, 32'h7);
    av_go(OFF_STATION, 1'b0, 32'h0);
    av_chk(OFF_STATION, 32'h1);
    av_go(OFF_STATION, 1'b0, 32'hf8);
    av_go(OFF_STATION, 1'b0, 32'h5);
    av_chk(OFF_STATION, 32'h5);
    avs_byteenable <= 4'he;
    av_go(OFF_STATION, 1'b0, 32'h7);
    avs_byteenable <= 4'hf;
    av_chk(OFF_STATION, 32'h5);
    av_go(OFF_BAUD, 1'b0, 32'h9);
    av_go(OFF_BAUD, 1'b0, 32'ha);
    av_chk(OFF_BAUD, 32'h9);
    av_chk(OFF_ACTIVE, 32'h160);
    av_chk(5'h18, 32'h0);
    reload();
    av_chk(OFF_ACTIVE, 32'h597);
    $display("test staging done");
    for (int k = 0; k < 4; k++) begin
      av_go(OFF_FORMAT, 1'b0, 32'(k + 4));
      reload();
      cmp32("format", {28'h0, k == 0, k >= 2, k == 3, 1'b1},
            {28'h0, link_stop2, link_parity_en, link_parity_odd, link_modified});
    end
    n = 0;
    while (link_baud_tick !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    n = 1;
    while (link_baud_tick !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    cmp32("tick_gap", 32'd8, n);
    $display("test format done");
    send(8'h05, 16'h3eff, 1'b0);
    send(8'h05, 16'h3fff, 1'b1);
    send(8'h00, 16'h0000, 1'b0);
    send(8'h07, 16'h0001, 1'b0);
    chk_dec();
    av_chk(OFF_DROPS, 32'h1);
    av_go(OFF_FORMAT, 1'b0, 32'h0);
    reload();
    md_q = 1'b0;
    send(8'h05, 16'd16199, 1'b0);
    send(8'h05, 16'd16299, 1'b0);
    send(8'h05, 16'd0, 1'b1);
    chk_dec();
    $display("test decode done");
    dec_ready <= 1'b0;
    send(8'h05, 16'd41, 1'b0);
    send(8'h05, 16'd42, 1'b0);
    fork
      send(8'h05, 16'd43, 1'b1);
    join_none
    repeat (4) @(posedge sys_clk);
    cmp32("req_ready", 32'h0, {31'h0, req_ready});
    dec_ready <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk_dec();
    $display("test buffer done");
    av_go(OFF_BAUD, 1'b0, 32'h2);
    i_master.pulse_evt(1'b0);
    repeat (4) @(posedge sys_clk);
    av_chk(OFF_ACTIVE, 32'h10590);
    cmp32("baud_code", 32'h9, {28'h0, link_baud_code});
    i_master.pulse_evt(1'b1);
    cmp32("baud_code", 32'h2, {28'h0, link_baud_code});
    $display("test link reload done");
    tally_and_finish();
  end
endmodule // tb_modbus_slave_serial_config
